// ==== rtl/lprb_cfg.svh ====
// Constants for the log page response builder
`ifndef LPRB_CFG_SVH
`define LPRB_CFG_SVH
//------------------------------------------------------------------------------
// Functional notes
// (R01) Page opens with code byte, zero byte, 16-bit page length.
// (R02) Page length equals last transferred byte index minus three.
// (R03) Each parameter: 16-bit code, control byte, length byte, value bytes.
// (R04) Suppress bit 0 refreshes event snapshot; 1 keeps the stored one.
// (R05) Save-inhibit control bit always reported as one.
// (R06) Target-save-inhibit conflicts; a single constant selects the value.
// (R07) Threshold-compare enable always zero, no comparison performed.
// (R08) Threshold criterion is don't-care, sent as zero.
// (R09) List-format bit zero for counters, one for list entries.
// (R10) Length byte shorter than value truncates the value.
// (R11) Values are counters, on/off states, or event text strings.
// (R12) Page 00h returns length 0002 then bytes 00h and 32h.
// (R13) Event page carries the most recent events, one entry each.
// (R14) Newest event code 0, older ones count down from FFFF.
// (R15) Entry length byte equals bytes following it.
// (R16) Event text is unterminated ASCII, length byte fixes count.
// (R17) No partial parameter; stop after the last complete one.
// (R18) Output starts at pointer's code; zero pointer returns everything.
// (R19) Initiator asks cumulative values and leaves save-parameters zero.
// (R20) Stop at highest supported code or allocation length, earliest.
// (R21) Page codes other than 00h and 32h end with an error.
// (R22) One byte per cycle under valid/ready, last byte marked.
//------------------------------------------------------------------------------

//------------------------------------------------------------------------------
// Page layout
//------------------------------------------------------------------------------
`define LPRB_PG_SUPPORTED 8'h00
`define LPRB_PG_EVENTS 8'h32
`define LPRB_HDR_LEN 16'd4
`define LPRB_PAR_HDR_LEN 8'd4
`define LPRB_SUP_PAY 16'h0002
`define LPRB_SUP_TOT 16'd6
`define LPRB_PC_CUMULATIVE 2'b01
`define LPRB_TSI_VAL 1'b1
`define LPRB_SAVE_INH_VAL 1'b1
`define LPRB_THR_EN_VAL 1'b0
`define LPRB_THR_CRIT_VAL 2'b00
`define LPRB_LIST_FMT_VAL 1'b1

//------------------------------------------------------------------------------
// Register map
//------------------------------------------------------------------------------
`define LPRB_REG_CTRL 8'h00
`define LPRB_REG_STATUS 8'h04
`define LPRB_REG_EVCHAR 8'h08
`define LPRB_REG_EVPUSH 8'h0c
`define LPRB_CTRL_EN_BIT 0
`define LPRB_CTRL_CLR_BIT 1
`define LPRB_CTRL_EN_RST 1'b1
`endif

// ==== rtl/lprb_pkg.sv ====
// Types shared by the log page response builder
package lprb_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SIZE, ST_EMIT, ST_DONE} lprb_state_e;
  typedef logic [7:0] lprb_byte_t;
  typedef logic [15:0] lprb_word_t;
endpackage : lprb_pkg

// ==== rtl/lprb_evt_if.sv ====
// Carrier between register slave, event store and page core
`timescale 1ns/1ps
interface lprb_evt_if #(parameter int NEV = 16, parameter int MAXC = 64) ();
  localparam int AW = $clog2(NEV);
  logic wr_char;
  logic [7:0] char_data;
  logic push;
  logic clr;
  logic enable;
  logic [AW-1:0] head;
  logic [AW:0] count;
  logic [AW-1:0] rd_slot;
  logic [7:0] rd_idx;
  logic [7:0] rd_len;
  logic [7:0] rd_char;
  logic busy;
  logic last_err;
  modport regs (output wr_char, char_data, push, clr, enable, input count, busy, last_err);
  modport store (input wr_char, char_data, push, clr, rd_slot, rd_idx,
                 output head, count, rd_len, rd_char);
  modport core (output rd_slot, rd_idx, busy, last_err,
                input head, count, rd_len, rd_char, enable);
endinterface : lprb_evt_if

// ==== rtl/lprb_event_store.sv ====
// Ring of recent event strings with a staging line
`timescale 1ns/1ps
`include "lprb_cfg.svh"
module lprb_event_store #(
  parameter int NEV = 16,
  parameter int MAXC = 64
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  lprb_evt_if.store ev
);
  import lprb_pkg::*;
  localparam int AW = $clog2(NEV);

  logic [MAXC*8-1:0] mem_r [NEV];
  logic [7:0] len_r [NEV];
  logic [MAXC*8-1:0] stg_r;
  logic [7:0] stg_cnt_r;
  logic [AW-1:0] head_r;
  logic [AW:0] count_r;

  // Staging line; characters beyond capacity are dropped, so text is cut short
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      stg_cnt_r <= 8'h00;
    end else if (ev.clr || ev.push) begin
      stg_cnt_r <= 8'h00;
    end else if (ev.wr_char && (stg_cnt_r < 8'(MAXC))) begin
      stg_r[stg_cnt_r*8 +: 8] <= ev.char_data; // R10
      stg_cnt_r <= stg_cnt_r + 8'h01;
    end
  end

  // Commit newest entry; an empty line is refused since a value needs a byte
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || ev.clr) begin
      head_r <= '0;
      count_r <= '0;
    end else if (ev.push && (stg_cnt_r != 8'h00)) begin // R03
      mem_r[head_r] <= stg_r; // R13
      len_r[head_r] <= stg_cnt_r;
      head_r <= head_r + 1'b1;
      if (count_r != (AW+1)'(NEV)) begin
        count_r <= count_r + 1'b1;
      end
    end
  end

  // Read port, combinational into the core's output register
  assign ev.head = head_r;
  assign ev.count = count_r;
  assign ev.rd_len = len_r[ev.rd_slot];
  assign ev.rd_char = mem_r[ev.rd_slot][ev.rd_idx*8 +: 8]; // R16
endmodule : lprb_event_store

// ==== rtl/lprb_apb_regs.sv ====
// APB slave with control, status and event loading registers
`timescale 1ns/1ps
`include "lprb_cfg.svh"
module lprb_apb_regs (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  lprb_evt_if.regs ev
);
  import lprb_pkg::*;

  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic en_r;
  logic wr_char_r;
  logic push_r;
  logic clr_r;
  logic [7:0] char_r;
  logic setup;
  logic hit;
  logic wr_acc;

  assign setup = psel_i && !penable_i;
  assign wr_acc = psel_i && penable_i && pready_r && pwrite_i;
  assign hit = (paddr_i == `LPRB_REG_CTRL) || (paddr_i == `LPRB_REG_STATUS) ||
               (paddr_i == `LPRB_REG_EVCHAR) || (paddr_i == `LPRB_REG_EVPUSH);

  // No wait state: answer decided in setup, given in the first access cycle
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !hit; // Stands only in the cycle that pready does
      if (setup) begin
        prdata_r <= 32'h0000_0000;
        if (!pwrite_i && paddr_i == `LPRB_REG_CTRL) begin
          prdata_r <= {31'h0000_0000, en_r};
        end else if (!pwrite_i && paddr_i == `LPRB_REG_STATUS) begin
          prdata_r <= {21'h00_0000, 9'(ev.count), ev.last_err, ev.busy};
        end
      end
    end
  end

  // Writes land at the completing edge; strobes last one cycle
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      en_r <= `LPRB_CTRL_EN_RST;
      wr_char_r <= 1'b0;
      push_r <= 1'b0;
      clr_r <= 1'b0;
      char_r <= 8'h00;
    end else begin
      wr_char_r <= wr_acc && (paddr_i == `LPRB_REG_EVCHAR);
      push_r <= wr_acc && (paddr_i == `LPRB_REG_EVPUSH);
      clr_r <= wr_acc && (paddr_i == `LPRB_REG_CTRL) && pwdata_i[`LPRB_CTRL_CLR_BIT];
      if (wr_acc && paddr_i == `LPRB_REG_CTRL) begin
        en_r <= pwdata_i[`LPRB_CTRL_EN_BIT];
      end
      if (wr_acc && paddr_i == `LPRB_REG_EVCHAR) begin
        char_r <= pwdata_i[7:0];
      end
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign ev.enable = en_r;
  assign ev.wr_char = wr_char_r;
  assign ev.push = push_r;
  assign ev.clr = clr_r;
  assign ev.char_data = char_r;
endmodule : lprb_apb_regs

// ==== rtl/lprb_log_page_builder.sv ====
// Log page response builder: request in, page bytes out
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "lprb_cfg.svh"
module lprb_log_page_builder #(
  parameter int NEV = 16,
  parameter int MAXC = 64
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire lprb_pkg::lprb_byte_t req_page_code_i,
  input wire lprb_pkg::lprb_word_t req_pointer_i,
  input wire lprb_pkg::lprb_word_t req_alloc_len_i,
  input wire logic req_update_suppress_i,
  input wire logic [1:0] req_page_control_i,
  input wire logic req_save_parameters_i,
  output lprb_pkg::lprb_byte_t dat_byte_o,
  output logic dat_valid_o,
  output logic dat_last_o,
  input wire logic dat_ready_i,
  output logic done_o,
  output logic done_err_o
);
  import lprb_pkg::*;
  localparam int AW = $clog2(NEV);

  //----------------------------------------------------------------------------
  // Submodules
  //----------------------------------------------------------------------------
  lprb_evt_if #(.NEV(NEV), .MAXC(MAXC)) ev ();

  lprb_apb_regs u_regs (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .ev(ev.regs)
  );

  lprb_event_store #(.NEV(NEV), .MAXC(MAXC)) u_store (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .ev(ev.store)
  );

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  lprb_state_e st_r;
  logic req_ready_r;
  logic [7:0] page_r;
  logic [15:0] alloc_r;
  logic [15:0] age0_r;
  logic [15:0] age_r;
  logic upd_r;
  logic [AW-1:0] snap_head_r;
  logic [AW:0] snap_cnt_r;
  logic [16:0] acc_r;
  logic [15:0] pay_r;
  logic [15:0] tot_r;
  logic [15:0] bcnt_r;
  logic [8:0] poff_r;
  logic err_r;
  logic last_err_r;
  logic vld_r;
  logic last_r;
  logic [7:0] byte_r;
  logic done_r;
  logic done_err_r;
  logic take;
  logic bad;
  logic load;
  logic in_range;
  logic fits;
  logic ent_end;
  logic [17:0] need;
  logic [7:0] cur_byte;
  logic [7:0] ctrl_byte;
  logic [15:0] code;

  assign take = req_valid_i && req_ready_r;
  // Unknown pages, disabled block or a non-cumulative request end in error
  assign bad = !((req_page_code_i == `LPRB_PG_SUPPORTED) ||
                 (req_page_code_i == `LPRB_PG_EVENTS)) || // R21
               !ev.enable ||
               (req_page_control_i != `LPRB_PC_CUMULATIVE) || req_save_parameters_i; // R19

  // Entry sizing: header plus text must still fit inside the allocation
  assign in_range = age_r < 16'(snap_cnt_r); // R20
  assign need = 18'(acc_r) + 18'(`LPRB_HDR_LEN) + 18'(`LPRB_PAR_HDR_LEN) + 18'(ev.rd_len);
  assign fits = need <= 18'(alloc_r); // R17
  assign ent_end = poff_r == (9'(ev.rd_len) + 9'd3); // R15
  assign load = (st_r == ST_EMIT) && (bcnt_r < tot_r) && (!vld_r || dat_ready_i); // R22

  // Oldest entries sit furthest behind the snapshot head
  assign ev.rd_slot = snap_head_r - AW'(1) - age_r[AW-1:0];
  assign ev.rd_idx = 8'(poff_r - 9'd4);
  assign ev.busy = st_r != ST_IDLE;
  assign ev.last_err = last_err_r;

  // Control byte of every event entry
  assign ctrl_byte = {upd_r, `LPRB_SAVE_INH_VAL, // R04 R05
                      `LPRB_TSI_VAL, // R06
                      `LPRB_THR_EN_VAL, `LPRB_THR_CRIT_VAL, // R07 R08
                      1'b0, `LPRB_LIST_FMT_VAL}; // R09
  assign code = 16'h0000 - age_r; // R14

  //----------------------------------------------------------------------------
  // Byte selection for the current stream position
  //----------------------------------------------------------------------------
  always_comb begin
    cur_byte = 8'h00;
    if (bcnt_r == 16'd0) begin
      cur_byte = {2'b00, page_r[5:0]}; // R01
    end else if (bcnt_r == 16'd1) begin
      cur_byte = 8'h00; // R01
    end else if (bcnt_r == 16'd2) begin
      cur_byte = pay_r[15:8]; // R02
    end else if (bcnt_r == 16'd3) begin
      cur_byte = pay_r[7:0]; // R02
    end else if (page_r == `LPRB_PG_SUPPORTED) begin
      cur_byte = (bcnt_r == 16'd4) ? `LPRB_PG_SUPPORTED : `LPRB_PG_EVENTS; // R12
    end else begin
      unique case (poff_r)
        9'd0: cur_byte = code[15:8]; // R03
        9'd1: cur_byte = code[7:0];
        9'd2: cur_byte = ctrl_byte;
        9'd3: cur_byte = ev.rd_len; // R15
        default: cur_byte = ev.rd_char; // R11 R16
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // Sequencer
  //----------------------------------------------------------------------------
  // Sizing runs first so the page length is known before the header leaves
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      st_r <= ST_IDLE;
      req_ready_r <= 1'b1;
      page_r <= 8'h00;
      alloc_r <= 16'h0000;
      age0_r <= 16'h0000;
      age_r <= 16'h0000;
      upd_r <= 1'b0;
      acc_r <= 17'h00000;
      pay_r <= 16'h0000;
      tot_r <= 16'h0000;
      err_r <= 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          if (take) begin
            req_ready_r <= 1'b0;
            page_r <= req_page_code_i;
            alloc_r <= req_alloc_len_i;
            age0_r <= 16'h0000 - req_pointer_i; // R18
            age_r <= 16'h0000 - req_pointer_i;
            upd_r <= req_update_suppress_i;
            acc_r <= 17'h00000;
            err_r <= bad;
            if (bad) begin
              st_r <= ST_DONE; // R21
            end else if (req_page_code_i == `LPRB_PG_SUPPORTED) begin
              pay_r <= `LPRB_SUP_PAY; // R12
              tot_r <= (req_alloc_len_i < `LPRB_SUP_TOT) ? req_alloc_len_i : `LPRB_SUP_TOT;
              st_r <= ST_EMIT;
            end else begin
              st_r <= ST_SIZE;
            end
          end
        end
        ST_SIZE: begin
          if (in_range && fits) begin
            acc_r <= 17'(need - 18'(`LPRB_HDR_LEN)); // R17
            age_r <= age_r + 16'h0001;
          end else begin
            pay_r <= acc_r[15:0]; // R02
            tot_r <= (alloc_r < `LPRB_HDR_LEN) ? alloc_r : (acc_r[15:0] + `LPRB_HDR_LEN);
            age_r <= age0_r;
            st_r <= ST_EMIT;
          end
        end
        ST_EMIT: begin
          if (load && bcnt_r >= `LPRB_HDR_LEN && ent_end) begin
            age_r <= age_r + 16'h0001; // R14
          end
          if (tot_r == 16'h0000 || (vld_r && last_r && dat_ready_i)) begin
            st_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          req_ready_r <= 1'b1;
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Snapshot of the ring; a suppressed update reuses the previous one
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      snap_head_r <= '0;
      snap_cnt_r <= '0;
    end else if (take && !req_update_suppress_i) begin
      snap_head_r <= ev.head; // R04
      snap_cnt_r <= ev.count;
    end
  end

  // Stream position within page and within the current entry
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || st_r != ST_EMIT) begin
      bcnt_r <= 16'h0000;
      poff_r <= 9'h000;
    end else if (load) begin
      bcnt_r <= bcnt_r + 16'h0001;
      if (bcnt_r >= `LPRB_HDR_LEN) begin
        poff_r <= ent_end ? 9'h000 : poff_r + 9'h001; // R10
      end
    end
  end

  // Output stage holds the byte until the sink takes it
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      vld_r <= 1'b0;
      last_r <= 1'b0;
      byte_r <= 8'h00;
    end else if (load) begin
      vld_r <= 1'b1; // R22
      byte_r <= cur_byte;
      last_r <= bcnt_r == (tot_r - 16'h0001); // R22
    end else if (dat_ready_i) begin
      vld_r <= 1'b0;
      last_r <= 1'b0;
    end
  end

  // Completion pulse and sticky last outcome for status readback
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      done_r <= 1'b0;
      done_err_r <= 1'b0;
      last_err_r <= 1'b0;
    end else begin
      done_r <= st_r == ST_DONE;
      done_err_r <= (st_r == ST_DONE) && err_r; // R21
      if (st_r == ST_DONE) begin
        last_err_r <= err_r;
      end
    end
  end

  assign req_ready_o = req_ready_r;
  assign dat_byte_o = byte_r;
  assign dat_valid_o = vld_r;
  assign dat_last_o = last_r;
  assign done_o = done_r;
  assign done_err_o = done_err_r;

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  logic [15:0] ocnt_r;

  // Count of bytes handed out in the current response
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || done_r) begin
      ocnt_r <= 16'h0000;
    end else if (vld_r && dat_ready_i) begin
      ocnt_r <= ocnt_r + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_bad_req;
    take && bad;
  endsequence
  sequence s_stall;
    vld_r && !dat_ready_i;
  endsequence
  sequence s_last_taken;
    vld_r && last_r && dat_ready_i;
  endsequence

  a_hdr_code_top: assert property (vld_r && ocnt_r == 16'd0 |-> byte_r[7:6] == 2'b00) // R01
    else $error("page code byte has upper bits set");
  a_hdr_zero_byte: assert property (vld_r && ocnt_r == 16'd1 |-> byte_r == 8'h00) // R01
    else $error("header byte one not zero");
  a_page_len_end: assert property (
    vld_r && last_r && page_r == `LPRB_PG_EVENTS && ocnt_r >= 16'd4
    |-> ocnt_r == pay_r + 16'd3) // R02
    else $error("page length disagrees with last byte index");
  a_within_alloc: assert property (vld_r |-> ocnt_r < alloc_r) // R20
    else $error("byte sent beyond allocation length");
  a_sup_list: assert property (
    vld_r && page_r == `LPRB_PG_SUPPORTED && ocnt_r == 16'd5 |-> byte_r == `LPRB_PG_EVENTS) // R12
    else $error("supported page list wrong");
  a_ctrl_fixed: assert property (
    load && page_r == `LPRB_PG_EVENTS && bcnt_r >= 16'd4 && poff_r == 9'd2 |->
    cur_byte[6] && !cur_byte[4] && cur_byte[0]) // R05
    else $error("control byte fixed bits wrong");
  a_newest_code: assert property (
    load && page_r == `LPRB_PG_EVENTS && bcnt_r >= 16'd4 && poff_r <= 9'd1 && age_r == 16'd0
    |-> cur_byte == 8'h00) // R14
    else $error("newest event code not zero");
  a_entry_len: assert property (
    load && page_r == `LPRB_PG_EVENTS && bcnt_r >= 16'd4 && poff_r == 9'd3
    |-> cur_byte == ev.rd_len && cur_byte != 8'h00) // R15
    else $error("entry length byte wrong");
  a_snap_refresh: assert property (
    take && !req_update_suppress_i |=> snap_cnt_r == $past(ev.count)) // R04
    else $error("snapshot not refreshed");
  a_bad_page_err: assert property (
    s_bad_req |=> (!vld_r throughout ##1 (done_r && done_err_r))) // R21
    else $error("rejected request produced data or no error");
  a_stall_hold: assert property (s_stall |=> vld_r && $stable(byte_r) && $stable(last_r)) // R22
    else $error("byte changed while stalled");
  a_last_done: assert property (s_last_taken |=> st_r == ST_DONE ##1 done_r && !done_err_r) // R22
    else $error("completion missing after last byte");
endmodule : lprb_log_page_builder

// ==== tb/lprb_data_sink.sv ====
// Data-in sink standing in for the initiator's receive side
`timescale 1ns/1ps
module lprb_data_sink (
  input wire logic clk_sys_i,
  input wire logic stall_i,
  input wire lprb_pkg::lprb_byte_t dat_byte_i,
  input wire logic dat_valid_i,
  input wire logic dat_last_i,
  output logic dat_ready_o
);
  import lprb_pkg::*;
  logic [7:0] byte_q[$];
  logic last_q[$];
  logic [1:0] cnt_r = 2'h0;
  // Free running phase for the stall pattern
  always @(posedge clk_sys_i) begin
    cnt_r <= cnt_r + 2'h1;
  end
  // Two idle cycles in four when stalling, so held bytes get exercised
  assign dat_ready_o = !stall_i || cnt_r[1];
  // Take a byte on each edge with valid and ready
  always @(posedge clk_sys_i) begin
    if (dat_valid_i === 1'b1 && dat_ready_o === 1'b1) begin
      byte_q.push_back(dat_byte_i);
      last_q.push_back(dat_last_i);
    end
  end
endmodule : lprb_data_sink

// ==== tb/log_page_response_builder_bench.sv ====
// Self-checking bench for the log page response builder
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", n, e, s); end end
module log_page_response_builder_bench;
  import lprb_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic req_valid = 1'b0;
  logic req_ready;
  lprb_byte_t pg = 8'h00;
  lprb_word_t ptr = 16'h0;
  lprb_word_t alen = 16'h0;
  logic sup = 1'b0;
  logic [1:0] pc = 2'b01;
  logic sp = 1'b0;
  lprb_byte_t dbyte;
  logic dvalid;
  logic dlast;
  logic dready;
  logic done;
  logic derr;
  logic stall = 1'b0;
  int failures = 0;
  int cmp_count = 0;
  logic [7:0] exp_q[$];
  logic [31:0] rd;
  logic err;

  //----------------------------------------------------------------------------
  // Clock, design and sink
  //----------------------------------------------------------------------------
  initial begin
    forever #2.5 clk_sys_i = !clk_sys_i;
  end
  lprb_log_page_builder dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .req_valid_i(req_valid), .req_ready_o(req_ready), .req_page_code_i(pg),
    .req_pointer_i(ptr), .req_alloc_len_i(alen), .req_update_suppress_i(sup),
    .req_page_control_i(pc), .req_save_parameters_i(sp), .dat_byte_o(dbyte),
    .dat_valid_o(dvalid), .dat_last_o(dlast), .dat_ready_i(dready),
    .done_o(done), .done_err_o(derr));
  lprb_data_sink u_sink (.clk_sys_i(clk_sys_i), .stall_i(stall), .dat_byte_i(dbyte),
    .dat_valid_i(dvalid), .dat_last_i(dlast), .dat_ready_o(dready));

  //----------------------------------------------------------------------------
  // Shared tasks
  //----------------------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // One APB transfer; waits for pready, never assumes a latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Expected page header and event entries
  task automatic hdr(input lprb_byte_t p, input lprb_word_t len);
    exp_q = '{p, 8'h00, len[15:8], len[7:0]};
  endtask : hdr
  task automatic ent(input lprb_word_t c, input lprb_byte_t k, input string s);
    exp_q.push_back(c[15:8]);
    exp_q.push_back(c[7:0]);
    exp_q.push_back(k);
    exp_q.push_back(8'(s.len()));
    for (int i = 0; i < s.len(); i++) exp_q.push_back(s[i]);
  endtask : ent

  // Offer a request, wait for completion, compare the stream with exp_q
  task automatic req(input lprb_byte_t p, input lprb_word_t pt, input lprb_word_t al,
                     input logic s, input logic [1:0] c, input logic v, input logic e);
    int n;
    n = 0;
    u_sink.byte_q.delete();
    u_sink.last_q.delete();
    @(posedge clk_sys_i);
    req_valid <= 1'b1;
    pg <= p;
    ptr <= pt;
    alen <= al;
    sup <= s;
    pc <= c;
    sp <= v;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (done !== 1'b1 && n < 3000);
    `CHK("done", 1'b1, done)
    `CHK("error flag", e, derr)
    `CHK("byte count", exp_q.size(), u_sink.byte_q.size())
    foreach (exp_q[i]) begin
      `CHK("byte", exp_q[i], u_sink.byte_q[i])
      `CHK("last", i == exp_q.size() - 1, u_sink.last_q[i])
    end
  endtask : req

  //----------------------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    // Supported page whole, under stall, and cut by allocation
    exp_q = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h32};
    req(8'h00, 16'h0, 16'd6, 1'b0, 2'b01, 1'b0, 1'b0);
    stall <= 1'b1;
    req(8'h00, 16'h0, 16'd40, 1'b0, 2'b01, 1'b0, 1'b0);
    exp_q = '{8'h00, 8'h00, 8'h00};
    req(8'h00, 16'h0, 16'd3, 1'b0, 2'b01, 1'b0, 1'b0);
    exp_q = {};
    req(8'h00, 16'h0, 16'd0, 1'b0, 2'b01, 1'b0, 1'b0);
    // Refused requests give no bytes
    req(8'h10, 16'h0, 16'd40, 1'b0, 2'b01, 1'b0, 1'b1);
    req(8'h00, 16'h0, 16'd40, 1'b0, 2'b00, 1'b0, 1'b1);
    req(8'h32, 16'h0, 16'd40, 1'b0, 2'b01, 1'b1, 1'b1);
    // Register reset value, unmapped slot, enable off
    apb(1'b0, 8'h00, 32'h0);
    `CHK("ctrl enable", 1'b1, rd[0])
    `CHK("mapped error", 1'b0, err)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    apb(1'b1, 8'h00, 32'h0);
    req(8'h00, 16'h0, 16'd40, 1'b0, 2'b01, 1'b0, 1'b1);
    apb(1'b1, 8'h00, 32'h1);
    // Load two events, older AB then newer C
    apb(1'b1, 8'h08, 32'h41);
    apb(1'b1, 8'h08, 32'h42);
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b1, 8'h08, 32'h43);
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    `CHK("event count", 9'd2, rd[10:2])
    // Full event page, newest first, control byte fixed bits
    hdr(8'h32, 16'd11);
    ent(16'h0000, 8'h61, "C");
    ent(16'hffff, 8'h61, "AB");
    req(8'h32, 16'h0, 16'd100, 1'b0, 2'b01, 1'b0, 1'b0);
    // One byte short of the second entry: no partial entry
    hdr(8'h32, 16'd5);
    ent(16'h0000, 8'h61, "C");
    req(8'h32, 16'h0, 16'd14, 1'b0, 2'b01, 1'b0, 1'b0);
    // Pointer at the older entry, suppressed refresh
    hdr(8'h32, 16'd6);
    ent(16'hffff, 8'he1, "AB");
    req(8'h32, 16'hffff, 16'd100, 1'b1, 2'b01, 1'b0, 1'b0);
    hdr(8'h32, 16'd0);
    req(8'h32, 16'hfffe, 16'd100, 1'b0, 2'b01, 1'b0, 1'b0);
    // Clearing the ring leaves a bare header
    apb(1'b1, 8'h00, 32'h3);
    req(8'h32, 16'h0, 16'd100, 1'b0, 2'b01, 1'b0, 1'b0);
    final_report();
  end

  // Cut a hang short well past the expected run time
  initial begin
    #100000;
    failures++;
    final_report();
  end
endmodule : log_page_response_builder_bench
